//--- rtl/opdec_map.svh
// Purpose: Field codes and positions for the operand field decoder
// Assumes: Included by bare name from rtl files
// Notes:   Definitions only
`ifndef OPDEC_MAP_SVH
`define OPDEC_MAP_SVH
`define MOD_NODISP   2'b00
`define MOD_D8       2'b01
`define MOD_DFULL    2'b10
`define MOD_REG      2'b11
`define RM_D16_ONLY  3'b110
`define RM_D32_ONLY  3'b101
`define RM_SIB       3'b100
`define IDX_NONE     3'b100
`define BASE_SP      3'b100
`define BASE_BP      3'b101
`define SS_ONE       2'b00
`define SEG_ES       3'b000
`define SEG_CS       3'b001
`define SEG_SS       3'b010
`define SEG_DS       3'b011
`define SEG_FS       3'b100
`define SEG_GS       3'b101
`define SPC_NONE     3'b000
`define SPC_CTRL     3'b001
`define SPC_DBG      3'b010
`define SPC_TEST     3'b011
`define DISP_NONE    2'b00
`define DISP_8       2'b01
`define DISP_16      2'b10
`define DISP_32      2'b11
`define REG16_BX     3'b011
`define REG16_BP     3'b101
`define REG16_SI     3'b110
`define REG16_DI     3'b111
`define REG_NONE     4'hf
`endif

//--- rtl/opdec_pkg.sv
// Purpose: Types for the operand field decoder
// Assumes: Nothing
// Notes:   Constants live in opdec_map.svh
package opdec_pkg;
  typedef logic [2:0] seg_t;
  typedef logic [3:0] reg_t;
endpackage

//--- rtl/operand_field_decoder.sv
// Purpose: Registered decode of address mode, sib and operand qualifier fields
// Assumes: Inputs come from same-clock prefetch logic; one result per cycle
// Notes:   All outputs registered, one cycle after inputs
// Summary of operation
// [RL1] 16-bit mode: mod/rm form address, d16 special
// [RL2] 32-bit no sib: base reg, d32 special
// [RL3] Displacement precedes immediate data bytes
// [RL4] Sib present: 32-bit, rm 100, mod not 11
// [RL5] Scale 00..11 gives 1,2,4,8
// [RL6] Index 100 means none; scale must be 00
// [RL7] Base 101 with mod 00: no base, d32
// [RL8] Scaled index is index times scale
// [RL9] Sib stack default for sp, bp with disp
// [RL10] Width bit 0 byte, 1 full size
// [RL11] Two-bit selector: es, cs, ss, ds
// [RL12] Three-bit selector adds fs, gs; 110/111 reserved
// [RL13] Register from opcode, reg, or rm when mod 11
// [RL14] Width 0 picks low/high byte registers
// [RL15] Bp-based addressing uses stack segment
// [RL16] String destination via di always extra segment
// [RL17] Direction bit swaps reg source/destination
// [RL18] Sign-extend 8-bit immediate when s set
// [RL19] Condition bits 3:1 select, bit 0 negates
// [RL20] Condition codes map overflow through less-or-equal
// [RL21] Special selector: cr0/2/3, dr0-3, dr6, tr6
// [RL22] Code 111 is dr7 or tr7
// [RL23] Flag reserved segment and special codes invalid
`timescale 1ns/1ps
`default_nettype none
`include "opdec_map.svh"
module operand_field_decoder
(
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        addr32,         // 32-bit address mode in effect
  input  wire logic        op32,           // 32-bit operand size in effect
  input  wire logic [7:0]  modrm,          // Address mode byte
  input  wire logic [7:0]  sib,            // Byte after address mode byte
  input  wire logic        has_w,          // Opcode carries a width bit
  input  wire logic        w_bit,
  input  wire logic        d_bit,
  input  wire logic        s_bit,
  input  wire logic        imm_is8,        // Immediate field is 8 bits
  input  wire logic [31:0] imm_in,
  input  wire logic        string_dst,     // Operand is string destination
  input  wire logic        ovr_valid,      // Segment override prefix seen
  input  wire logic [2:0]  ovr_seg,
  input  wire logic [1:0]  two_bit_segment_selector,
  input  wire logic [2:0]  three_bit_segment_selector,
  input  wire logic        opc_reg_valid,  // Register field from opcode
  input  wire logic [2:0]  opc_reg,
  input  wire logic [3:0]  tttn,
  input  wire logic [1:0]  spc_class,      // 0 ctrl, 1 debug, 2 test
  input  wire logic [2:0]  spc_code,
  output logic             sib_present,
  output logic [1:0]       disp_size,      // None, 8, 16, 32 bits
  output logic [1:0]       disp_offset,    // Bytes after opcode before displacement
  output logic             base_valid,
  output logic [3:0]       base_reg,       // 32-bit or 16-bit base code
  output logic             index_valid,
  output logic [3:0]       index_reg,
  output logic [3:0]       scale_mult,     // 1, 2, 4 or 8
  output logic             ea_undefined,
  output logic [2:0]       eff_seg,        // Segment for memory operand
  output logic             mem_operand,
  output logic [5:0]       opnd_bits,      // 8, 16 or 32
  output logic [2:0]       seg2_dec,
  output logic [2:0]       seg3_dec,
  output logic             seg3_invalid,
  output logic [3:0]       reg_src,        // Bit 3 set: byte register form
  output logic [3:0]       reg_dst,
  output logic             rm_is_dst,
  output logic [31:0]      imm_out,
  output logic [2:0]       cond_sel,
  output logic             cond_negate,
  output logic [2:0]       spc_kind,
  output logic [2:0]       spc_index,
  output logic             spc_invalid
);

  // Subfields of the address mode byte and the sib byte
  wire logic [1:0] mode = modrm[7:6];
  wire logic [2:0] regf = modrm[5:3];
  wire logic [2:0] rm   = modrm[2:0];
  wire logic [1:0] sc   = sib[7:6];
  wire logic [2:0] idx  = sib[5:3];
  wire logic [2:0] bse  = sib[2:0];

  // Register code with width qualifier; byte form keeps code, flags it in bit 3
  function automatic opdec_pkg::reg_t reg_code(input logic [2:0] c, input logic hw,
                                               input logic w);
    reg_code = (hw && !w) ? {1'b1, c} : {1'b0, c};
  endfunction

  // Address field decode
  logic       sib_d, bv_d, iv_d, und_d;
  logic [1:0] dsz_d;
  logic [2:0] seg_d;
  logic [3:0] br_d, ir_d, sm_d;
  always_comb
  begin
    sib_d = 1'b0;
    dsz_d = `DISP_NONE;
    bv_d  = 1'b0;
    br_d  = `REG_NONE;
    iv_d  = 1'b0;
    ir_d  = `REG_NONE;
    sm_d  = 4'h1;
    und_d = 1'b0;
    seg_d = `SEG_DS;
    if (!addr32)
    begin
      // [RL1] 16-bit forms
      if (mode == `MOD_D8)
        dsz_d = `DISP_8;
      else if (mode == `MOD_DFULL)
        dsz_d = `DISP_16;
      if (mode == `MOD_NODISP && rm == `RM_D16_ONLY)
        dsz_d = `DISP_16;
      else if (mode != `MOD_REG)
      begin
        bv_d = 1'b1;  // Every form but bare d16 has a base, si and di included
        case (rm)
          3'b000, 3'b001, 3'b111: br_d = {1'b0, `REG16_BX};
          3'b010, 3'b011, 3'b110: br_d = {1'b0, `REG16_BP};
          3'b100:                 br_d = {1'b0, `REG16_SI};
          default:                br_d = {1'b0, `REG16_DI};
        endcase
        iv_d = !rm[2];
        ir_d = iv_d ? (rm[0] ? {1'b0, `REG16_DI} : {1'b0, `REG16_SI}) : `REG_NONE;
        // [RL15] bp base uses stack segment
        if (br_d == {1'b0, `REG16_BP} && bv_d)
          seg_d = `SEG_SS;
      end
    end
    else if (mode != `MOD_REG)
    begin
      // [RL4] sib byte detection
      sib_d = (rm == `RM_SIB);
      if (mode == `MOD_D8)
        dsz_d = `DISP_8;
      else if (mode == `MOD_DFULL)
        dsz_d = `DISP_32;
      if (!sib_d)
      begin
        // [RL2] base register or bare d32
        if (mode == `MOD_NODISP && rm == `RM_D32_ONLY)
          dsz_d = `DISP_32;
        else
        begin
          bv_d = 1'b1;
          br_d = {1'b0, rm};
          if (rm == `BASE_BP)
            seg_d = `SEG_SS;
        end
      end
      else
      begin
        // [RL5] scale decode; [RL8] index multiplier
        sm_d = 4'h1 << sc;
        // [RL6] no index code
        iv_d  = (idx != `IDX_NONE);
        ir_d  = iv_d ? {1'b0, idx} : `REG_NONE;
        und_d = !iv_d && sc != `SS_ONE;
        // [RL7] base 101 with mod 00 takes d32
        if (mode == `MOD_NODISP && bse == `BASE_BP)
          dsz_d = `DISP_32;
        else
        begin
          bv_d = 1'b1;
          br_d = {1'b0, bse};
        end
        // [RL9] stack segment default
        if (bse == `BASE_SP || (bse == `BASE_BP && mode != `MOD_NODISP))
          seg_d = `SEG_SS;
      end
    end
    if (ovr_valid && mode != `MOD_REG)
      seg_d = ovr_seg;
    // [RL16] string destination ignores override
    if (string_dst)
      seg_d = `SEG_ES;
  end

  // Address results
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      sib_present  <= 1'b0;
      disp_size    <= `DISP_NONE;
      disp_offset  <= 2'h0;
      base_valid   <= 1'b0;
      base_reg     <= `REG_NONE;
      index_valid  <= 1'b0;
      index_reg    <= `REG_NONE;
      scale_mult   <= 4'h1;
      ea_undefined <= 1'b0;
      eff_seg      <= `SEG_DS;
      mem_operand  <= 1'b0;
    end
    else
    begin
      sib_present  <= sib_d;
      disp_size    <= dsz_d;
      // [RL3] displacement right after addressing bytes
      disp_offset  <= sib_d ? 2'h2 : 2'h1;
      base_valid   <= bv_d;
      base_reg     <= br_d;
      index_valid  <= iv_d;
      index_reg    <= ir_d;
      scale_mult   <= sm_d;
      ea_undefined <= und_d;
      eff_seg      <= seg_d;
      mem_operand  <= (mode != `MOD_REG);
    end
  end

  // Operand qualifiers, registers, immediate
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      opnd_bits    <= 6'h20;
      seg2_dec     <= `SEG_ES;
      seg3_dec     <= `SEG_ES;
      seg3_invalid <= 1'b0;
      reg_src      <= 4'h0;
      reg_dst      <= 4'h0;
      rm_is_dst    <= 1'b0;
      imm_out      <= 32'h0;
    end
    else
    begin
      // [RL10] width bit selects byte or full
      opnd_bits <= (has_w && !w_bit) ? 6'h08 : (op32 ? 6'h20 : 6'h10);
      // [RL11] two-bit selector
      seg2_dec <= {1'b0, two_bit_segment_selector};
      // [RL12] three-bit selector; [RL23] reserved codes flagged
      seg3_dec     <= three_bit_segment_selector[2:1] == 2'b11 ? `SEG_ES
                      : three_bit_segment_selector;
      seg3_invalid <= three_bit_segment_selector[2:1] == 2'b11;
      // [RL13] [RL14] [RL17] register roles by direction
      rm_is_dst <= !d_bit;
      if (opc_reg_valid)
      begin
        reg_src <= reg_code(opc_reg, has_w, w_bit);
        reg_dst <= reg_code(opc_reg, has_w, w_bit);
      end
      else if (d_bit)
      begin
        reg_dst <= reg_code(regf, has_w, w_bit);
        reg_src <= mode == `MOD_REG ? reg_code(rm, has_w, w_bit) : `REG_NONE;
      end
      else
      begin
        reg_src <= reg_code(regf, has_w, w_bit);
        reg_dst <= mode == `MOD_REG ? reg_code(rm, has_w, w_bit) : `REG_NONE;
      end
      // [RL18] sign extend 8-bit immediate
      if (s_bit && imm_is8)
        imm_out <= {{24{imm_in[7]}}, imm_in[7:0]};
      else
        imm_out <= imm_in;
    end
  end

  // Condition and special register fields
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      cond_sel    <= 3'h0;
      cond_negate <= 1'b0;
      spc_kind    <= `SPC_NONE;
      spc_index   <= 3'h0;
      spc_invalid <= 1'b0;
    end
    else
    begin
      // [RL19] [RL20] ttt selects condition, n negates
      cond_sel    <= tttn[3:1];
      cond_negate <= tttn[0];
      spc_index   <= spc_code;
      // [RL21] [RL22] [RL23] special register map
      spc_kind    <= (spc_class == 2'h3) ? `SPC_NONE : {1'b0, spc_class} + 3'h1;
      spc_invalid <= (spc_class == 2'h0) ? !(spc_code == 3'h0 || spc_code[2:1] == 2'b01)
                     : (spc_class == 2'h1) ? (spc_code[2:1] == 2'b10)
                     : (spc_class == 2'h2) ? (spc_code[2:1] != 2'b11) : 1'b1;
    end
  end

  // Checks; one clock domain, quiet while reset is held
  default clocking chk_cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  property p_sib;
    (addr32 && rm == `RM_SIB && mode != `MOD_REG) |=> sib_present;
  endproperty
  a_sib: assert property (p_sib) else $error("sib not detected"); // [RL4]
  property p_d16;
    (!addr32 && mode == `MOD_NODISP && rm == `RM_D16_ONLY)
      |=> (disp_size == `DISP_16 && !base_valid);
  endproperty
  a_d16: assert property (p_d16) else $error("bare d16 wrong"); // [RL1]
  property p_d32;
    (addr32 && mode == `MOD_NODISP && rm == `RM_D32_ONLY)
      |=> (disp_size == `DISP_32 && !base_valid);
  endproperty
  a_d32: assert property (p_d32) else $error("bare d32 wrong"); // [RL2]
  property p_scale;
    (addr32 && sib_d && sc == 2'b11) |=> scale_mult == 4'h8;
  endproperty
  a_scale: assert property (p_scale) else $error("scale not 8"); // [RL5]
  property p_noidx;
    (sib_d && idx == `IDX_NONE) |=> !index_valid && (ea_undefined == ($past(sc) != `SS_ONE));
  endproperty
  a_noidx: assert property (p_noidx) else $error("no-index wrong"); // [RL6]
  property p_str;
    string_dst |=> eff_seg == `SEG_ES;
  endproperty
  a_str: assert property (p_str) else $error("string seg not es"); // [RL16]
  property p_sext;
    (s_bit && imm_is8 && imm_in[7]) |=> imm_out[31:8] == 24'hffffff;
  endproperty
  a_sext: assert property (p_sext) else $error("no sign extend"); // [RL18]
  property p_seg3;
    (three_bit_segment_selector[2:1] == 2'b11) |=> (seg3_invalid && seg3_dec == `SEG_ES);
  endproperty
  a_seg3: assert property (p_seg3) else $error("reserved seg selected"); // [RL23]
endmodule
`default_nettype wire

//--- sim/fetch_model.sv
// Purpose: Fetch stage stand-in that splits one random word into decoder fields
// Assumes: Word changes shortly after the clock edge, held for a whole cycle
// Notes:   Keeps sib scale at 00 with no index unless told to misbehave
`timescale 1ns/1ps
`default_nettype none
module fetch_model
(
  input  wire logic [63:0] rnd,
  input  wire logic        bad,
  output var logic         addr32,
  output var logic         op32,
  output var logic [7:0]   modrm,
  output var logic [7:0]   sib,
  output var logic [31:0]  imm_in,
  output var logic [1:0]   seg2,
  output var logic [2:0]   seg3,
  output var logic [2:0]   ovr_seg,
  output var logic [12:0]  flags,
  output var logic [12:0]  fields
);
  // Field slicing; override segment stays within the six real segments
  always_comb
  begin
    addr32  = rnd[16];
    op32    = rnd[17];
    modrm   = rnd[7:0];
    sib     = (rnd[13:11] == 3'h4 && !bad) ? {2'h0, rnd[13:8]} : rnd[15:8];
    imm_in  = rnd[63:32];
    seg2    = rnd[29:28];
    seg3    = rnd[32:30];
    ovr_seg = rnd[27] ? {2'h2, rnd[25]} : {1'h0, rnd[26:25]};
    flags   = {5'h0, rnd[33], rnd[24:18]};
    fields  = rnd[45:33];
  end
endmodule
`default_nettype wire

//--- sim/operand_field_decoder_tb.sv
// Purpose: Self-checking bench for the operand field decoder
// Assumes: Outputs follow inputs by exactly one clock
// Notes:   Random words from a fixed-seed xorshift plus a few corner cases
`timescale 1ns/1ps
`default_nettype none
module operand_field_decoder_tb;
  logic mclk, resetn, bad;
  logic [63:0] rnd, x;
  logic addr32, op32, sib_present, base_valid, index_valid, ea_undefined;
  logic mem_operand, seg3_invalid, rm_is_dst, cond_negate, spc_invalid;
  logic [7:0] modrm, sib;
  logic [31:0] imm_in, imm_out, ie;
  logic [1:0] seg2, disp_size, disp_offset, md;
  logic [2:0] seg3, ovr_seg, eff_seg, seg2_dec, seg3_dec, cond_sel, spc_kind, spc_index, rm, sg;
  logic [12:0] flags, fields;
  logic [3:0] base_reg, index_reg, scale_mult, reg_src, reg_dst, rr, mr;
  logic [5:0] opnd_bits;
  int error_cnt, compares;
  fetch_model i_fetch (.rnd(rnd), .bad(bad), .addr32(addr32), .op32(op32), .modrm(modrm),
    .sib(sib), .imm_in(imm_in), .seg2(seg2), .seg3(seg3), .ovr_seg(ovr_seg), .flags(flags),
    .fields(fields));
  operand_field_decoder i_dut (.mclk(mclk), .resetn(resetn), .addr32(addr32), .op32(op32),
    .modrm(modrm), .sib(sib), .has_w(flags[0]), .w_bit(flags[1]), .d_bit(flags[2]),
    .s_bit(flags[3]), .imm_is8(flags[4]), .imm_in(imm_in), .string_dst(flags[5]),
    .ovr_valid(flags[6]), .ovr_seg(ovr_seg), .two_bit_segment_selector(seg2),
    .three_bit_segment_selector(seg3), .opc_reg_valid(fields[0]), .opc_reg(fields[3:1]),
    .tttn(fields[7:4]), .spc_class(fields[9:8]), .spc_code(fields[12:10]),
    .sib_present(sib_present), .disp_size(disp_size), .disp_offset(disp_offset),
    .base_valid(base_valid), .base_reg(base_reg), .index_valid(index_valid),
    .index_reg(index_reg), .scale_mult(scale_mult), .ea_undefined(ea_undefined),
    .eff_seg(eff_seg), .mem_operand(mem_operand), .opnd_bits(opnd_bits),
    .seg2_dec(seg2_dec), .seg3_dec(seg3_dec), .seg3_invalid(seg3_invalid),
    .reg_src(reg_src), .reg_dst(reg_dst), .rm_is_dst(rm_is_dst), .imm_out(imm_out),
    .cond_sel(cond_sel), .cond_negate(cond_negate), .spc_kind(spc_kind),
    .spc_index(spc_index), .spc_invalid(spc_invalid));

  // 250 MHz clock
  always #2 mclk = ~mclk;

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    compares++;
    if (got !== ex)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // Byte form flag joins the register code when the width bit is 0
  function automatic logic [3:0] rcode(input logic [2:0] c);
    return {flags[0] & ~flags[1], c};
  endfunction

  // Expected base code; 16-bit forms use 3 bx, 5 bp, 6 si, 7 di; 4'hf when none
  function automatic logic [3:0] exp_base(input logic a32, input logic [1:0] m,
                                          input logic [2:0] r, input logic [2:0] b);
    logic [3:0] e;
    e = 4'hf;
    if (m == 2'h3 || (!a32 && m == 2'h0 && r == 3'h6))
      e = 4'hf;
    else if (!a32)
      e = (r == 3'h4) ? 4'h6 : (r == 3'h5) ? 4'h7 : (r inside {3'h2, 3'h3, 3'h6}) ? 4'h5 : 4'h3;
    else if (r == 3'h4)
      e = (m == 2'h0 && b == 3'h5) ? 4'hf : {1'b0, b};
    else
      e = (m == 2'h0 && r == 3'h5) ? 4'hf : {1'b0, r};
    return e;
  endfunction

  // Expected index code; only the four two-register 16-bit forms and sib carry one
  function automatic logic [3:0] exp_index(input logic a32, input logic [1:0] m,
                                           input logic [2:0] r, input logic [2:0] i);
    logic [3:0] e;
    e = 4'hf;
    if (m != 2'h3 && !a32 && r < 3'h4)
      e = r[0] ? 4'h7 : 4'h6;
    else if (m != 2'h3 && a32 && r == 3'h4 && i != 3'h4)
      e = {1'b0, i};
    return e;
  endfunction

  // Every output against the inputs still standing on the wires
  task automatic check_all();
    logic       sp;
    logic [1:0] dz;
    logic [3:0] bx;
    logic [3:0] ix;
    md = modrm[7:6];
    rm = modrm[2:0];
    sp = addr32 && rm == 3'h4 && md != 2'h3;
    chk("sib_present", sp, sib_present);
    // Mod 11 never carries a displacement, in either address size
    if (md == 2'h3)
      dz = 2'h0;
    else if (!addr32)
      dz = (md == 2'h0 && rm == 3'h6) ? 2'h2 : md;
    else
      dz = (md == 2'h2 || (md == 2'h0 && (sp ? sib[2:0] : rm) == 3'h5)) ? 2'h3 : md;
    if (!addr32)
      chk("disp16", dz, disp_size);
    else if (sp)
      chk("disp_sib", dz, disp_size);
    else
      chk("disp32", dz, disp_size);
    if (md != 2'h3)
      chk("disp_offset", sp ? 2 : 1, disp_offset);
    bx = exp_base(addr32, md, rm, sib[2:0]);
    ix = exp_index(addr32, md, rm, sib[5:3]);
    chk("base_reg", bx, base_reg);
    chk("base_valid", bx != 4'hf, base_valid);
    chk("index_reg", ix, index_reg);
    chk("index_valid", ix != 4'hf, index_valid);
    if (sp)
    begin
      chk("scale", 32'h1 << sib[7:6], scale_mult);
      chk("ea_undef", sib[5:3] == 4 && sib[7:6] != 0, ea_undefined);
      chk("index_valid", sib[5:3] != 4, index_valid);
    end
    if (!addr32)
      sg = (rm == 3'h2 || rm == 3'h3 || (rm == 3'h6 && md != 2'h0)) ? 3'h2 : 3'h3;
    else if (sp)
      sg = (sib[2:0] == 3'h4 || (sib[2:0] == 3'h5 && md != 2'h0)) ? 3'h2 : 3'h3;
    else
      sg = (rm == 3'h5 && md != 2'h0) ? 3'h2 : 3'h3;
    if (flags[6])
      sg = ovr_seg;
    if (flags[5])
      sg = 3'h0;
    if (md != 2'h3)
      chk("eff_seg", sg, eff_seg);
    chk("mem_operand", md != 3, mem_operand);
    chk("opnd_bits", (flags[0] && !flags[1]) ? 8 : (op32 ? 32 : 16), opnd_bits);
    chk("seg2", {1'b0, seg2}, seg2_dec);
    chk("seg3_invalid", seg3 > 5, seg3_invalid);
    if (seg3 < 6)
      chk("seg3", seg3, seg3_dec);
    rr = fields[0] ? rcode(fields[3:1]) : rcode(modrm[5:3]);
    mr = (md == 3) ? rcode(rm) : 4'hf;
    chk("reg_src", fields[0] ? rr : (flags[2] ? mr : rr), reg_src);
    chk("reg_dst", fields[0] ? rr : (flags[2] ? rr : mr), reg_dst);
    chk("rm_is_dst", !flags[2], rm_is_dst);
    // Full word compared: an unextended immediate must pass through untouched
    ie = (flags[3] && flags[4]) ? {{24{imm_in[7]}}, imm_in[7:0]} : imm_in;
    chk("imm", ie, imm_out);
    chk("cond", fields[7:4], {cond_sel, cond_negate});
    chk("spc_kind", fields[9:8] == 3 ? 0 : fields[9:8] + 1, spc_kind);
    chk("spc_index", fields[12:10], spc_index);
    case (fields[9:8])
      2'h0: chk("spc_inv", !(fields[12:10] inside {0, 2, 3}), spc_invalid);
      2'h1: chk("spc_inv", fields[12:10] inside {4, 5}, spc_invalid);
      2'h2: chk("spc_inv", fields[12:10] < 6, spc_invalid);
      default: chk("spc_inv", 1, spc_invalid);
    endcase
  endtask

  // Idle values that nine of the outputs must show while reset is held
  task automatic rst_check();
    chk("rst_scale", 1, scale_mult);
    chk("rst_seg", 3, eff_seg);
    chk("rst_base", 15, base_reg);
    chk("rst_index", 15, index_reg);
    chk("rst_sib", 0, sib_present);
    chk("rst_disp", 0, disp_size);
    chk("rst_bits", 32, opnd_bits);
    chk("rst_imm", 0, imm_out);
    chk("rst_spc", 0, spc_kind);
  endtask

  // One input set, one edge, then compare
  task automatic step(input logic [63:0] v, input logic b);
    rnd = v;
    bad = b;
    @(posedge mclk);
    #1;
    check_all();
  endtask

  function automatic logic [63:0] xorshift(input logic [63:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 7);
    return s ^ (s << 17);
  endfunction

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Watchdog well beyond the expected 2019 cycles
  initial
  begin
    #100000;
    error_cnt++;
    final_report();
  end

  initial
  begin
    mclk = 0;
    resetn = 0;
    bad = 0;
    rnd = 64'h0;
    error_cnt = 0;
    compares = 0;
    repeat (8) @(posedge mclk);
    #1;
    rst_check();
    resetn = 1;
    step(64'h1_8844, 0);
    step(64'h0_0006, 0);
    step(64'h1_0005, 0);
    step(64'h1_2504, 0);
    step(64'h1_e004, 1);
    step(64'h0_0046, 0);
    step(64'h0_0044, 0);
    step(64'h1_6544, 0);
    x = 64'd34;
    repeat (2000)
    begin
      x = xorshift(x);
      step(x, x[50] & x[51] & x[52]);
    end
    // Reset again mid-run; decode must resume on the first edge after release
    resetn = 0;
    repeat (2) @(posedge mclk);
    #1;
    rst_check();
    resetn = 1;
    step(64'h1_8844, 0);
    final_report();
  end
endmodule
`default_nettype wire
